/* File: irdcfg_assertions.sv */
// Checker for the index/data configuration port between host and controller
`timescale 1ns/1ps
`default_nettype none
module irdcfg_assertions
  import irdcfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_sel,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  logic [7:0] last_idx_r; // Index most recently sent to the index port
  wire logic idx_wr = io_wr && (io_sel == SEL_INDEX); // Index port write
  wire logic dat_wr = io_wr && (io_sel == SEL_DATA); // Data port write
  // Known places: 02h, 08h and a2h to a7h
  wire logic idx_known = (last_idx_r == IDX_POWER_DOWN_CONTROL) ||
    (last_idx_r == IDX_MODE_IDENTIFICATION) ||
    (last_idx_r[7:3] == 5'h14 && last_idx_r[2:1] != 2'h0);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Track the index so read results can be judged
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_idx_r <= 8'h00;
    end else if (idx_wr) begin
      last_idx_r <= io_wdata;
    end
  end

  AST_QUIET_AT_LOAD: assert property (
    $fell(rst_i) |-> !io_wr && !io_rd)
    else $error("strobe on the default load edge");
  AST_NO_DUAL_STROBE: assert property (!(io_wr && io_rd))
    else $error("read and write strobes together");
  AST_INDEX_FOLLOW: assert property (idx_wr |=> dat_wr || io_rd)
    else $error("index write not followed by a data access");
  AST_WRITE_PAIR: assert property (idx_wr ##1 dat_wr |=> dat_wr)
    else $error("data write not sent as a pair");
  AST_READ_DATA_PORT: assert property (
    io_rd |-> io_sel && $past(idx_wr))
    else $error("read not on data port right after index");
  AST_READ_PULSE: assert property (io_rd |=> !io_rd)
    else $error("read strobe longer than one cycle");
  AST_ID_READ: assert property (
    io_rd && last_idx_r == IDX_MODE_IDENTIFICATION
    |=> io_rdata == MODE_ID_HOST_DMA)
    else $error("mode identification read wrong");
  AST_UNMAPPED_READ: assert property (
    io_rd && !idx_known |=> io_rdata == UNMAPPED_READ)
    else $error("unmapped index did not read zero");
  AST_RDATA_HOLD: assert property (
    !$past(io_rd) |-> $stable(io_rdata))
    else $error("read data moved without a read");

  // Main traffic kinds
  cover property (idx_wr ##1 dat_wr ##1 dat_wr);
  cover property (io_rd && last_idx_r == IDX_MODE_IDENTIFICATION);
  cover property (io_rd && !idx_known);
endmodule
`default_nettype wire

/* File: irdcfg_device.sv */
// Controller end: config registers, power-up defaults, DMA and IRQ routing
`timescale 1ns/1ps
`default_nettype none
module irdcfg_device #(
  parameter int NUM_DMA_LINES = 4 // External request/acknowledge pairs
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  irdcfg_port_if.device port,
  input wire logic default_strap_bit2_i,
  input wire logic default_strap_bit1_i,
  input wire logic default_strap_bit0_i,
  input wire logic opmode_strap_bit2_i,
  input wire logic opmode_strap_bit1_i,
  input wire logic opmode_strap_bit0_i,
  input wire logic rx_dma_req_i,
  input wire logic tx_dma_req_i,
  input wire logic dma_dual_mode_i,
  input wire logic single_dir_tx_i,
  input wire logic [NUM_DMA_LINES-1:0] dma_ack_n_i,
  input wire logic uart_irq_i,
  input wire logic fir_irq_i,
  output logic [NUM_DMA_LINES-1:0] dma_req_o,
  output logic rx_dma_ack_o,
  output logic tx_dma_ack_o,
  output logic serial_port_irq_out_o,
  output logic fast_infrared_irq_out_o,
  output logic irq3_o,
  output logic irq4_o,
  output logic core_enable_o,
  output logic mode_match_o,
  output logic uart_enable_o,
  output logic fir_pio_enable_o,
  output logic fir_dma_ready_o,
  output logic pulse_irq_mode_o,
  output logic [15:0] uart_base_o,
  output logic [15:0] fir_base_o,
  output logic [7:0] power_down_control_o
);
  import irdcfg_pkg::*;

  // Map an index to its slot in the writable array
  function automatic logic [2:0] idx_slot(input logic [7:0] idx);
    logic [2:0] s;
    s = SLOT_NONE;
    case (idx)
      IDX_POWER_DOWN_CONTROL: s = SLOT_PDC;
      IDX_DMA_LINE_SELECT: s = SLOT_DLS;
      IDX_INTERRUPT_ROUTING_CONFIG: s = SLOT_IRC;
      IDX_UART_BASE_HIGH: s = SLOT_UBH;
      IDX_UART_BASE_LOW: s = SLOT_UBL;
      IDX_FAST_IR_BASE_HIGH: s = SLOT_FBH;
      IDX_FAST_IR_BASE_LOW: s = SLOT_FBL;
      default: s = SLOT_NONE;
    endcase
    return s;
  endfunction

  logic [5:0] strap_s1_r; // First synchroniser stage, read only by stage two
  logic [5:0] strap_s2_r; // Settled strap levels
  logic [NUM_DMA_LINES-1:0] ack_s1_r; // Acknowledge pins, first stage
  logic [NUM_DMA_LINES-1:0] ack_s2_r; // Acknowledge pins, settled
  logic [7:0] cfg_r [NUM_SLOTS]; // Writable configuration registers
  logic load_pend_r; // High until defaults are taken after reset
  logic core_en_r; // Infrared core enabled
  logic match_r; // Operating-mode straps matched at load
  logic [7:0] index_r; // Index port contents
  logic armed_r; // First of two data writes seen
  logic [7:0] rdata_r; // Registered read data
  logic uart_irq_d_r; // Previous UART irq level for edge detection
  logic fir_irq_d_r; // Previous FAST_INFRARED irq level
  logic uart_pulse_r; // UART irq pulse
  logic fir_pulse_r; // FAST_INFRARED irq pulse
  logic irq3_r; // Shared pulse on IRQ3
  logic irq4_r; // Shared pulse on IRQ4

  wire [2:0] cfg_code = strap_s2_r[5:3];
  wire [2:0] mode_code = strap_s2_r[2:0];
  wire mode_ok = (mode_code == OPMODE_INDIRECT_DMA);
  // Foreign opmode loads the disabled set rather than a wrong one
  wire [2:0] eff_code = mode_ok ? cfg_code : STRAP_ALL_DISABLED;
  wire irdcfg_defaults_t dflt = irdcfg_default_set(eff_code);
  wire [2:0] cur_slot = idx_slot(index_r);
  wire is_id = (index_r == IDX_MODE_IDENTIFICATION);
  wire data_wr = port.io_wr && (port.io_sel == SEL_DATA);
  wire commit = data_wr && armed_r && (cur_slot != SLOT_NONE);
  wire [7:0] slot_rd = (cur_slot == SLOT_NONE) ? UNMAPPED_READ :
                       cfg_r[cur_slot];
  wire [7:0] data_rd = is_id ? MODE_ID_HOST_DMA : slot_rd;

  // Straps and acknowledge pins cross in through two flops; no reset so
  // the straps are settled when reset is released
  always_ff @(posedge sys_clk_i) begin
    strap_s1_r <= {default_strap_bit2_i, default_strap_bit1_i,
                   default_strap_bit0_i, opmode_strap_bit2_i,
                   opmode_strap_bit1_i, opmode_strap_bit0_i};
    strap_s2_r <= strap_s1_r;
    ack_s1_r <= dma_ack_n_i;
    ack_s2_r <= ack_s1_r;
  end

  // Register file, default load and index/data port
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        cfg_r[i] <= ZERO_BYTE;
      end
      load_pend_r <= 1'b1;
      core_en_r <= 1'b0;
      match_r <= 1'b0;
      index_r <= ZERO_BYTE;
      armed_r <= 1'b0;
      rdata_r <= ZERO_BYTE;
    end else if (load_pend_r) begin
      // First edge after reset falls: take the strap-selected set
      load_pend_r <= 1'b0;
      cfg_r[SLOT_PDC] <= POWER_DOWN_RESET;
      cfg_r[SLOT_DLS] <= dflt[47:40];
      cfg_r[SLOT_IRC] <= dflt[39:32];
      cfg_r[SLOT_UBH] <= dflt[31:24];
      cfg_r[SLOT_UBL] <= dflt[23:16];
      cfg_r[SLOT_FBH] <= dflt[15:8];
      cfg_r[SLOT_FBL] <= dflt[7:0];
      core_en_r <= (eff_code != STRAP_ALL_DISABLED);
      match_r <= mode_ok;
    end else begin
      if (port.io_wr && (port.io_sel == SEL_INDEX)) begin
        // New index breaks any half-done data write
        index_r <= port.io_wdata;
        armed_r <= 1'b0;
      end else if (data_wr) begin
        // Two data writes with no index write or read between them guard against stray pokes
        armed_r <= !armed_r;
      end else if (port.io_rd) begin
        armed_r <= 1'b0;
      end
      if (commit) begin
        cfg_r[cur_slot] <= port.io_wdata;
        core_en_r <= 1'b1; // Any host programming wakes the core
      end
      if (port.io_rd) begin
        rdata_r <= (port.io_sel == SEL_INDEX) ? index_r : data_rd;
      end
    end
  end

  // Channel mapping decode
  wire [2:0] ch1_code = cfg_r[SLOT_DLS][DLS_CH1_LSB +: DLS_FIELD_W];
  wire [2:0] ch2_code = cfg_r[SLOT_DLS][DLS_CH2_LSB +: DLS_FIELD_W];
  wire ch1_on = core_en_r && (ch1_code != 3'h0);
  wire ch2_on = core_en_r && (ch2_code != 3'h0);
  wire [2:0] ch1_line = ch1_code - 3'h1;
  wire [2:0] ch2_line = ch2_code - 3'h1;
  wire dual = ch1_on && ch2_on && dma_dual_mode_i;
  // Single channel follows the direction software selects
  wire ch1_req = dual ? rx_dma_req_i :
                 (single_dir_tx_i ? tx_dma_req_i : rx_dma_req_i);
  wire ch2_req = dual && tx_dma_req_i;

  logic [NUM_DMA_LINES-1:0] ch1_ack_v; // Acks landing on channel 1's line
  logic [NUM_DMA_LINES-1:0] ch2_ack_v; // Acks landing on channel 2's line

  // Request fan-out and the acknowledge pin of the same number
  genvar g;
  generate
    for (g = 0; g < NUM_DMA_LINES; g++) begin : g_line
      wire hit1 = ch1_on && (ch1_line == 3'(g));
      wire hit2 = ch2_on && (ch2_line == 3'(g));
      assign dma_req_o[g] = (hit1 && ch1_req) || (hit2 && ch2_req);
      assign ch1_ack_v[g] = hit1 && !ack_s2_r[g];
      assign ch2_ack_v[g] = hit2 && !ack_s2_r[g];
    end
  endgenerate

  wire ch1_ack = |ch1_ack_v;
  wire ch2_ack = |ch2_ack_v;
  assign rx_dma_ack_o = ch1_ack && (dual || !single_dir_tx_i);
  assign tx_dma_ack_o = dual ? ch2_ack :
                        (ch1_ack && single_dir_tx_i);

  // Interrupts are edge-to-pulse; level mode is not offered here
  wire irq_en = core_en_r && cfg_r[SLOT_IRC][IRC_ENABLE_BIT];
  wire to_irq4 = cfg_r[SLOT_IRC][IRC_SHARED_IRQ4_BIT];
  wire uart_rise = uart_irq_i && !uart_irq_d_r;
  wire fir_rise = fir_irq_i && !fir_irq_d_r;

  // Pulse generation and shared-pin steering
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      uart_irq_d_r <= 1'b0;
      fir_irq_d_r <= 1'b0;
      uart_pulse_r <= 1'b0;
      fir_pulse_r <= 1'b0;
      irq3_r <= 1'b0;
      irq4_r <= 1'b0;
    end else begin
      uart_irq_d_r <= uart_irq_i;
      fir_irq_d_r <= fir_irq_i;
      uart_pulse_r <= irq_en && uart_rise;
      fir_pulse_r <= irq_en && fir_rise;
      irq3_r <= irq_en && !to_irq4 && (uart_rise || fir_rise);
      irq4_r <= irq_en && to_irq4 && (uart_rise || fir_rise);
    end
  end

  assign port.io_rdata = rdata_r;
  assign serial_port_irq_out_o = uart_pulse_r;
  assign fast_infrared_irq_out_o = fir_pulse_r;
  assign irq3_o = irq3_r;
  assign irq4_o = irq4_r;
  assign core_enable_o = core_en_r;
  assign mode_match_o = match_r;
  assign uart_enable_o = core_en_r;
  assign fir_pio_enable_o = core_en_r;
  assign fir_dma_ready_o = ch1_on;
  // Advanced interrupt bit only clears pulse_irq_mode_o; the irq pulse logic ignores it
  assign pulse_irq_mode_o = !cfg_r[SLOT_IRC][IRC_ADVANCED_BIT];
  assign uart_base_o = {cfg_r[SLOT_UBH], cfg_r[SLOT_UBL]};
  assign fir_base_o = {cfg_r[SLOT_FBH], cfg_r[SLOT_FBL]};
  assign power_down_control_o = cfg_r[SLOT_PDC];

endmodule
`default_nettype wire

/* File: irdcfg_host.sv */
// Host end: sequences register reads and double data-port writes
`timescale 1ns/1ps
`default_nettype none
module irdcfg_host (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  irdcfg_port_if.host port,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_index_i,
  input wire logic [7:0] req_data_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  import irdcfg_pkg::*;

  irdcfg_state_t state_r; // Sequencer state
  irdcfg_state_t state_nxt; // Next state
  logic write_r; // Latched request kind
  logic [7:0] index_r; // Latched index
  logic [7:0] data_r; // Latched write byte
  logic [7:0] rdata_r; // Captured read byte
  logic done_r; // Completion pulse

  // Next-state decode; each bus step takes exactly one cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IRDCFG_IDLE: begin
        if (req_i) begin
          state_nxt = IRDCFG_INDEX;
        end
      end
      IRDCFG_INDEX: begin
        state_nxt = write_r ? IRDCFG_DATA1 : IRDCFG_READ;
      end
      // Two back-to-back data writes; the device drops a lone one
      IRDCFG_DATA1: state_nxt = IRDCFG_DATA2;
      IRDCFG_DATA2: state_nxt = IRDCFG_IDLE;
      IRDCFG_READ: state_nxt = IRDCFG_CAPTURE;
      IRDCFG_CAPTURE: state_nxt = IRDCFG_IDLE;
      default: state_nxt = IRDCFG_IDLE;
    endcase
  end

  // State, request latch and read capture
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= IRDCFG_IDLE;
      write_r <= 1'b0;
      index_r <= ZERO_BYTE;
      data_r <= ZERO_BYTE;
      rdata_r <= ZERO_BYTE;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= (state_r == IRDCFG_DATA2) || (state_r == IRDCFG_CAPTURE);
      if ((state_r == IRDCFG_IDLE) && req_i) begin
        // Mapping DMA lines, then the channel mode, is a software order
        write_r <= req_write_i;
        index_r <= req_index_i;
        data_r <= req_data_i;
      end
      if (state_r == IRDCFG_CAPTURE) begin
        rdata_r <= port.io_rdata;
      end
    end
  end

  // Port strobes decode straight from state
  assign port.io_wr = (state_r == IRDCFG_INDEX) ||
                      (state_r == IRDCFG_DATA1) ||
                      (state_r == IRDCFG_DATA2);
  assign port.io_rd = (state_r == IRDCFG_READ);
  assign port.io_sel = (state_r == IRDCFG_INDEX) ? SEL_INDEX : SEL_DATA;
  assign port.io_wdata = (state_r == IRDCFG_INDEX) ? index_r : data_r;
  assign busy_o = (state_r != IRDCFG_IDLE);
  assign done_o = done_r;
  assign rdata_o = rdata_r;

endmodule
`default_nettype wire

/* File: irdcfg_pkg.sv */
// Constants, default tables and types shared by both ends of the config port
package irdcfg_pkg;

  // Register index values seen through the index port
  localparam logic [7:0] IDX_POWER_DOWN_CONTROL = 8'h02;
  localparam logic [7:0] IDX_MODE_IDENTIFICATION = 8'h08;
  localparam logic [7:0] IDX_DMA_LINE_SELECT = 8'ha2;
  localparam logic [7:0] IDX_INTERRUPT_ROUTING_CONFIG = 8'ha3;
  localparam logic [7:0] IDX_UART_BASE_HIGH = 8'ha4;
  localparam logic [7:0] IDX_UART_BASE_LOW = 8'ha5;
  localparam logic [7:0] IDX_FAST_IR_BASE_HIGH = 8'ha6;
  localparam logic [7:0] IDX_FAST_IR_BASE_LOW = 8'ha7;

  // Fixed values
  localparam logic [7:0] POWER_DOWN_RESET = 8'h02;
  localparam logic [7:0] MODE_ID_HOST_DMA = 8'he2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] OPMODE_INDIRECT_DMA = 3'h2;
  localparam logic [2:0] STRAP_ALL_DISABLED = 3'h0;

  // Port select on the shared io strobe
  localparam logic SEL_INDEX = 1'b0;
  localparam logic SEL_DATA = 1'b1;

  // Slots of the writable register array
  localparam logic [2:0] SLOT_PDC = 3'h0;
  localparam logic [2:0] SLOT_DLS = 3'h1;
  localparam logic [2:0] SLOT_IRC = 3'h2;
  localparam logic [2:0] SLOT_UBH = 3'h3;
  localparam logic [2:0] SLOT_UBL = 3'h4;
  localparam logic [2:0] SLOT_FBH = 3'h5;
  localparam logic [2:0] SLOT_FBL = 3'h6;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam int NUM_SLOTS = 7;

  // Field positions in dma_line_select: code 0 none, n means request line n-1
  localparam int DLS_CH1_LSB = 0;
  localparam int DLS_CH2_LSB = 4;
  localparam int DLS_FIELD_W = 3;

  // Field positions in interrupt_routing_config
  localparam int IRC_ENABLE_BIT = 0;
  localparam int IRC_SHARED_IRQ4_BIT = 2;
  localparam int IRC_ADVANCED_BIT = 7;

  // Packed defaults: dls, irc, uart hi, uart lo, fir hi, fir lo
  typedef logic [47:0] irdcfg_defaults_t;

  // Default set chosen by the three configuration straps
  function automatic irdcfg_defaults_t irdcfg_default_set(
    input logic [2:0] code
  );
    irdcfg_defaults_t v;
    v = 48'h0004_03f8_0300;
    case (code)
      3'h0: v = 48'h0004_03f8_0300;
      3'h1: v = 48'h0005_03f8_0300;
      3'h2: v = 48'h0001_02f8_0300;
      3'h3: v = 48'h0005_03e8_0310;
      3'h4: v = 48'h0001_02e8_0310;
      3'h5: v = 48'h0005_0338_0330;
      3'h6: v = 48'h0101_02f8_0300;
      3'h7: v = 48'h2101_02f8_0300;
      default: v = 48'h0004_03f8_0300;
    endcase
    return v;
  endfunction

  // Host end sequencer states
  typedef enum logic [2:0] {
    IRDCFG_IDLE,
    IRDCFG_INDEX,
    IRDCFG_DATA1,
    IRDCFG_DATA2,
    IRDCFG_READ,
    IRDCFG_CAPTURE
  } irdcfg_state_t;

endpackage

/* File: irdcfg_port_if.sv */
// Index/data configuration port between the host and the controller
`timescale 1ns/1ps
`default_nettype none
interface irdcfg_port_if;
  logic io_wr; // One-cycle write strobe
  logic io_rd; // One-cycle read strobe
  logic io_sel; // Index port or data port
  logic [7:0] io_wdata; // Write byte
  logic [7:0] io_rdata; // Read byte, valid the cycle after io_rd

  modport device (
    input io_wr,
    input io_rd,
    input io_sel,
    input io_wdata,
    output io_rdata
  );

  modport host (
    output io_wr,
    output io_rd,
    output io_sel,
    output io_wdata,
    input io_rdata
  );
endinterface
`default_nettype wire

/* File: irdcfg_port_if_note_placeholder_removed.sv */
// Intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: irdcfg_tb.sv */
// Self-checking bench joining the host end and the controller end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irdcfg_pkg::*;
  logic sys_clk_i, rst_i; // Bench clock and reset
  logic req_i, req_write_i, busy_o, done_o; // Host user side
  logic [7:0] req_index_i, req_data_i, rdata_o;
  logic [2:0] strap, opm; // Default and mode straps
  logic rx_req, tx_req, dual, dir_tx, serial_port_irq_out, fast_infrared_irq_out; // Subsystem inputs
  logic [3:0] ack_n, dma_req; // ISA request/acknowledge lines
  logic rx_ack, tx_ack, sp_irq, fi_irq, irq3, irq4;
  logic core_en, match, uart_en, pio_en, dma_rdy, pulse_md;
  logic [15:0] uart_base, fir_base;
  logic [7:0] pdc;
  int bad_count, checks_done;
  logic [8:0] notes[$]; // Read flag and expected byte per host request
  logic [8:0] note;
  logic [47:0] v; // Expected dls, irc, uart hi/lo, fir hi/lo
  logic [7:0] wd[7]; // Bytes written in the overwrite pass
  logic en, s4;
  logic [7:0] xb; // Expected read byte
  logic [3:0] xq; // Expected request lines
  logic [1:0] xa; // Expected internal acknowledges
  // Expected default sets, one per strap code
  logic [47:0] dflt[8] = '{48'h0004_03f8_0300, 48'h0005_03f8_0300,
    48'h0001_02f8_0300, 48'h0005_03e8_0310, 48'h0001_02e8_0310,
    48'h0005_0338_0330, 48'h0101_02f8_0300, 48'h2101_02f8_0300};
  // Writable places only: power-down control, then a2h to a7h
  logic [7:0] idxs[7] = '{8'h02, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7};

  irdcfg_port_if u_irdcfg_port_if();

  irdcfg_device #(.NUM_DMA_LINES(4)) u_irdcfg_device (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .port(u_irdcfg_port_if),
    .default_strap_bit2_i(strap[2]), .default_strap_bit1_i(strap[1]),
    .default_strap_bit0_i(strap[0]), .opmode_strap_bit2_i(opm[2]),
    .opmode_strap_bit1_i(opm[1]), .opmode_strap_bit0_i(opm[0]),
    .rx_dma_req_i(rx_req), .tx_dma_req_i(tx_req), .dma_dual_mode_i(dual),
    .single_dir_tx_i(dir_tx), .dma_ack_n_i(ack_n), .uart_irq_i(serial_port_irq_out),
    .fir_irq_i(fast_infrared_irq_out), .dma_req_o(dma_req), .rx_dma_ack_o(rx_ack),
    .tx_dma_ack_o(tx_ack), .serial_port_irq_out_o(sp_irq),
    .fast_infrared_irq_out_o(fi_irq), .irq3_o(irq3), .irq4_o(irq4),
    .core_enable_o(core_en), .mode_match_o(match), .uart_enable_o(uart_en),
    .fir_pio_enable_o(pio_en), .fir_dma_ready_o(dma_rdy),
    .pulse_irq_mode_o(pulse_md), .uart_base_o(uart_base),
    .fir_base_o(fir_base), .power_down_control_o(pdc));

  irdcfg_host u_irdcfg_host (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .port(u_irdcfg_port_if),
    .req_i(req_i), .req_write_i(req_write_i), .req_index_i(req_index_i),
    .req_data_i(req_data_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o));

  irdcfg_assertions u_irdcfg_assertions (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .io_wr(u_irdcfg_port_if.io_wr), .io_rd(u_irdcfg_port_if.io_rd),
    .io_sel(u_irdcfg_port_if.io_sel), .io_wdata(u_irdcfg_port_if.io_wdata),
    .io_rdata(u_irdcfg_port_if.io_rdata));

  // Free-running 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Single comparison point, counts every check
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Straps settle well before release so the synchronisers see them
  task automatic boot(input logic [2:0] code, input logic [2:0] mode);
    strap = code;
    opm = mode;
    rst_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
  endtask

  // One host request; the note is judged by the watcher when done appears
  task automatic op(input logic wr, input logic [7:0] idx,
                    input logic [7:0] d, input logic [7:0] exp);
    int n;
    req_i = 1'b1;
    req_write_i = wr;
    req_index_i = idx;
    req_data_i = d;
    notes.push_back({~wr, exp});
    @(negedge sys_clk_i);
    req_i = 1'b0;
    chk(busy_o, 16'h0001);
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 20) begin
      bad_count++;
      close_out();
    end
  endtask

  // Raise one subsystem irq as a level and count output pulses
  task automatic irq_try(input logic which);
    int c_own, c3, c4;
    c_own = 0;
    c3 = 0;
    c4 = 0;
    if (which) fast_infrared_irq_out = 1'b1;
    else serial_port_irq_out = 1'b1;
    repeat (4) begin
      @(negedge sys_clk_i);
      c_own += int'(which ? fi_irq : sp_irq);
      c3 += int'(irq3);
      c4 += int'(irq4);
    end
    serial_port_irq_out = 1'b0;
    fast_infrared_irq_out = 1'b0;
    @(negedge sys_clk_i);
    chk(c_own[15:0], {15'h0, en});
    chk({c3[7:0], c4[7:0]}, {7'h0, en && !s4, 7'h0, en && s4});
  endtask

  // Watcher: a finished request retires the oldest note
  always @(negedge sys_clk_i) begin
    if (done_o === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[8]) chk(rdata_o, note[7:0]);
    end
  end

  initial begin
    bad_count = 0;
    checks_done = 0;
    {req_i, req_write_i, req_index_i, req_data_i} = 18'h0;
    {rx_req, tx_req, dual, dir_tx, serial_port_irq_out, fast_infrared_irq_out} = 6'h0;
    ack_n = 4'hf;
    void'($urandom(32'h81c1ccba));
    for (int c = 0; c < 8; c++) begin
      boot(c[2:0], OPMODE_INDIRECT_DMA);
      v = dflt[c];
      en = (c != 0);
      s4 = (c == 1 || c == 3 || c == 5);
      chk(pdc, 16'h0002);
      chk(uart_base, v[31:16]);
      chk(fir_base, v[15:0]);
      chk({core_en, uart_en, pio_en}, {3{en}});
      chk({match, pulse_md}, 16'h0003);
      chk(dma_rdy, c >= 6);
      op(1'b0, 8'h08, 8'h00, 8'he2);
      for (int i = 0; i < 7; i++) begin
        xb = (i == 0) ? 8'h02 : v[55-8*i -: 8];
        op(1'b0, idxs[i], 8'h00, xb);
      end
      // Both internal requests high, dual mode asked, direction random
      rx_req = 1'b1;
      tx_req = 1'b1;
      dual = 1'b1;
      dir_tx = 1'($urandom_range(0, 1));
      @(negedge sys_clk_i);
      xq = (c == 7) ? 4'h3 : ((c == 6) ? 4'h1 : 4'h0);
      chk(dma_req, xq);
      ack_n = 4'hc;
      repeat (5) @(negedge sys_clk_i);
      xa = (c == 7) ? 2'h3 : ((c == 6) ? {~dir_tx, dir_tx} : 2'h0);
      chk({rx_ack, tx_ack}, xa);
      {rx_req, tx_req, dual} = 3'h0;
      ack_n = 4'hf;
      irq_try(1'b0);
      irq_try(1'b1);
    end
    // Overwrite every writable place with random bytes and read back
    for (int i = 0; i < 7; i++) begin
      wd[i] = 8'($urandom());
      op(1'b1, idxs[i], wd[i], 8'h00);
      op(1'b0, idxs[i], 8'h00, wd[i]);
    end
    chk(uart_base, {wd[3], wd[4]});
    chk(fir_base, {wd[5], wd[6]});
    chk(pdc, wd[0]);
    op(1'b1, 8'h08, 8'($urandom()), 8'h00);
    op(1'b0, 8'h08, 8'h00, 8'he2);
    op(1'b0, 8'h55, 8'h00, 8'h00);
    // Host maps channel 1 onto line 2 on a no-DMA default
    boot(3'h1, OPMODE_INDIRECT_DMA);
    chk(dma_rdy, 16'h0);
    op(1'b1, 8'ha2, 8'h03, 8'h00);
    // Single channel on receive, else the random direction would mask rx
    dir_tx = 1'b0;
    rx_req = 1'b1;
    @(negedge sys_clk_i);
    chk({dma_rdy, dma_req}, 5'h14);
    rx_req = 1'b0;
    // Wrong operating mode straps give the disabled set
    boot(3'h3, 3'h0);
    chk({match, core_en}, 2'h0);
    chk(uart_base, 16'h03f8);
    close_out();
  end
endmodule
`default_nettype wire
